/* File: paf_pkg.sv */
/*
  paf_pkg: constants shared by the quasi-bidirectional port block.
  assumes: one reference clock, machine cycle of twelve clocks.
*/
`default_nettype none
package paf_pkg;
  // special function addresses of the port latches
  localparam logic [7:0] PAF_ADDR_PORT_ONE = 8'h90;
  localparam logic [7:0] PAF_ADDR_PORT_THREE = 8'hb0;
  localparam logic [7:0] PAF_ADDR_PORT_FIVE = 8'hd8;
  // reset values: every latch bit high so pins start as inputs
  localparam logic [7:0] PAF_RESET_PORT_ONE = 8'hff;
  localparam logic [7:0] PAF_RESET_PORT_THREE = 8'hff;
  localparam logic [3:0] PAF_RESET_PORT_FIVE = 4'hf;
  // width of the fifth port
  localparam int PAF_PORT_FIVE_WIDTH = 4;
  // machine cycle timing
  localparam int PAF_CLOCK_HZ = 10000000;
  localparam int PAF_CLOCKS_PER_MACHINE = 12;
  // field positions inside the third port
  localparam int PAF_BIT_SERIAL_DATA = 0;
  localparam int PAF_BIT_SERIAL_OUT = 1;
  localparam int PAF_BIT_IRQ_ZERO = 2;
  localparam int PAF_BIT_IRQ_ONE = 3;
  localparam int PAF_BIT_TIMER_ZERO = 4;
  localparam int PAF_BIT_TIMER_ONE = 5;
  localparam int PAF_BIT_WRITE_STROBE = 6;
  localparam int PAF_BIT_READ_STROBE = 7;
  // field positions inside the first port
  localparam int PAF_BIT_T2_COUNT = 0;
  localparam int PAF_BIT_T2_AUX = 1;
  localparam int PAF_BIT_PULSE_LOW = 3;
  // pending write phase type
  typedef enum logic [1:0] {
    PAF_IDLE = 2'b00,
    PAF_HELD = 2'b01,
    PAF_COMMIT = 2'b11
  } paf_commit_type;
endpackage : paf_pkg
`default_nettype wire

/* File: paf_pin_sync.sv */
/*
  paf_pin_sync: three-stage sampler for a vector of pin levels.
  assumes: pins are asynchronous to the reference clock.
*/
`default_nettype none
module paf_pin_sync
  import paf_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage_one; // metastable stage, read only by stage_two
  logic [WIDTH-1:0] stage_two;
  logic [WIDTH-1:0] stage_three;
  logic [WIDTH-1:0] next_level;

  // a bit moves only once stage two and three agree, which filters one-clock glitches
  always_comb begin
    next_level = level;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage_two[i] == stage_three[i]) begin
        next_level[i] = stage_three[i];
      end
    end
  end

  // registers; idle pins read high because of the weak pull-ups
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_one <= '1;
      stage_two <= '1;
      stage_three <= '1;
      level <= '1;
    end else begin
      stage_one <= pin_in;
      stage_two <= stage_one;
      stage_three <= stage_two;
      level <= next_level;
    end
  end
endmodule : paf_pin_sync
`default_nettype wire

/* File: paf_machine_tick.sv */
/*
  paf_machine_tick: divider making one pulse per machine cycle.
  assumes: the reference clock is the oscillator.
*/
`default_nettype none
module paf_machine_tick
  import paf_pkg::*;
#(
  parameter int DIVIDE = PAF_CLOCKS_PER_MACHINE
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [3:0] count; // clocks within the machine cycle
  logic [3:0] next_count;
  logic next_tick;

  // count down, pulse on wrap
  always_comb begin
    if (count == 4'h0) begin
      next_count = 4'(DIVIDE - 1);
      next_tick = 1'b1;
    end else begin
      next_count = count - 4'h1;
      next_tick = 1'b0;
    end
  end

  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 4'h0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule : paf_machine_tick
`default_nettype wire

/* File: paf_port_io.sv */
/*
  paf_port_io: port latches and alternate-function pin mux for the
  first, third and fifth ports of an 8051-class core.
  assumes: the core presents a special function address with read and
  write strobes, flags read-modify-write reads, and marks the last
  machine cycle of an instruction; peripherals run on the same clock.
*/
`default_nettype none
module paf_port_io
  import paf_pkg::*;
#(
  parameter int FIVE_WIDTH = PAF_PORT_FIVE_WIDTH
) (
  input wire logic REF_CLK,
  input wire logic RST,
  // special function register access from the core
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_RD,
  input wire logic SFR_RMW,
  input wire logic LAST_CYCLE,
  output logic [7:0] SFR_RDATA,
  output logic SFR_HIT,
  output logic MACHINE_TICK,
  // first port pins
  input wire logic [7:0] PORT_ONE_IN,
  output logic [7:0] PORT_ONE_OUT,
  output logic [7:0] PORT_ONE_OE,
  // third port pins
  input wire logic [7:0] PORT_THREE_IN,
  output logic [7:0] PORT_THREE_OUT,
  output logic [7:0] PORT_THREE_OE,
  // fifth port pins
  input wire logic [FIVE_WIDTH-1:0] PORT_FIVE_IN,
  output logic [FIVE_WIDTH-1:0] PORT_FIVE_OUT,
  output logic [FIVE_WIDTH-1:0] PORT_FIVE_OE,
  // peripheral side, first port
  output logic TIMER_TWO_COUNT_IN,
  output logic TIMER_TWO_AUX_IN,
  input wire logic PULSE_OUT_A,
  input wire logic PULSE_OUT_B,
  input wire logic PULSE_OUT_C,
  input wire logic PULSE_OUT_D,
  input wire logic PULSE_OUT_E,
  // peripheral side, third port
  input wire logic SERIAL_SYNC_MODE,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_TX_OR_CLOCK,
  output logic SERIAL_DATA_IN,
  output logic EXT_IRQ_ZERO_IN,
  output logic EXT_IRQ_ONE_IN,
  output logic TIMER_ZERO_GATE_IN,
  output logic TIMER_ONE_GATE_IN,
  output logic TIMER_ZERO_COUNT_IN,
  output logic TIMER_ONE_COUNT_IN,
  input wire logic EXT_MEM_ACTIVE,
  input wire logic EXT_WRITE_STROBE_N,
  input wire logic EXT_READ_STROBE_N
);
  logic [7:0] port_one_latch; // first port latch
  logic [7:0] port_three_latch; // third port latch
  logic [FIVE_WIDTH-1:0] port_five_latch; // fifth port latch
  logic [7:0] next_port_one_latch;
  logic [7:0] next_port_three_latch;
  logic [FIVE_WIDTH-1:0] next_port_five_latch;
  logic [7:0] pend_data; // write waiting for the last machine cycle
  logic [7:0] pend_addr;
  logic [7:0] next_pend_data;
  logic [7:0] next_pend_addr;
  paf_commit_type phase; // pending write state
  paf_commit_type next_phase;
  logic [7:0] one_level; // sampled pin levels
  logic [7:0] three_level;
  logic [FIVE_WIDTH-1:0] five_level;
  logic [7:0] one_alt; // alternate outputs, 1 where idle
  logic [7:0] three_alt;
  logic [7:0] next_rdata;
  logic next_hit;
  logic [7:0] next_one_pull;
  logic [7:0] next_three_pull;
  logic [FIVE_WIDTH-1:0] next_five_pull;
  logic [7:0] one_pull; // pull-down enables, registered
  logic [7:0] three_pull;
  logic [FIVE_WIDTH-1:0] five_pull;
  logic [7:0] next_alt_in; // registered peripheral inputs
  logic [7:0] alt_in;
  logic [1:0] next_t2_in;
  logic [1:0] t2_in;

  // read value of a latch widened to a byte, upper bits zero
  function automatic logic [7:0] paf_widen(input logic [FIVE_WIDTH-1:0] v);
    paf_widen = 8'(v);
  endfunction

  // pin input samplers; three flops swallow short glitches, so a level
  // shorter than two clocks may be missed by the peripherals
  paf_pin_sync #(.WIDTH(8)) u_sync_one (
    .clk(REF_CLK),
    .rst(RST),
    .pin_in(PORT_ONE_IN),
    .level(one_level)
  );
  paf_pin_sync #(.WIDTH(8)) u_sync_three (
    .clk(REF_CLK),
    .rst(RST),
    .pin_in(PORT_THREE_IN),
    .level(three_level)
  );
  paf_pin_sync #(.WIDTH(FIVE_WIDTH)) u_sync_five (
    .clk(REF_CLK),
    .rst(RST),
    .pin_in(PORT_FIVE_IN),
    .level(five_level)
  );

  // machine cycle pulse for the peripherals
  // free-running; not aligned to the core's instruction boundaries
  paf_machine_tick #(.DIVIDE(PAF_CLOCKS_PER_MACHINE)) u_tick (
    .clk(REF_CLK),
    .rst(RST),
    .tick(MACHINE_TICK)
  );

  // alternate outputs; an idle function holds its output high
  // bit 0 needs no receive mux: the input path always reads the sampled pin
  always_comb begin
    one_alt = 8'hff;
    one_alt[PAF_BIT_PULSE_LOW] = PULSE_OUT_A;
    one_alt[PAF_BIT_PULSE_LOW + 1] = PULSE_OUT_B;
    one_alt[PAF_BIT_PULSE_LOW + 2] = PULSE_OUT_C;
    one_alt[PAF_BIT_PULSE_LOW + 3] = PULSE_OUT_D;
    one_alt[PAF_BIT_PULSE_LOW + 4] = PULSE_OUT_E;
    three_alt = 8'hff;
    // data line driven only in synchronous mode
    three_alt[PAF_BIT_SERIAL_DATA] = SERIAL_SYNC_MODE ? SERIAL_DATA_OUT : 1'b1;
    // transmit data or shift clock, same pin either way
    three_alt[PAF_BIT_SERIAL_OUT] = SERIAL_TX_OR_CLOCK;
    // strobes only while the external bus cycle runs
    three_alt[PAF_BIT_WRITE_STROBE] = EXT_MEM_ACTIVE ? EXT_WRITE_STROBE_N : 1'b1;
    three_alt[PAF_BIT_READ_STROBE] = EXT_MEM_ACTIVE ? EXT_READ_STROBE_N : 1'b1;
  end

  // pull-down whenever latch or alternate asks for low
  always_comb begin
    next_one_pull = ~(port_one_latch & one_alt);
    next_three_pull = ~(port_three_latch & three_alt);
    next_five_pull = ~port_five_latch;
  end

  // pending write: a write is held until the instruction's last cycle
  // a second write before that cycle replaces the first, so the latest wins
  always_comb begin
    next_phase = phase;
    next_pend_data = pend_data;
    next_pend_addr = pend_addr;
    next_port_one_latch = port_one_latch;
    next_port_three_latch = port_three_latch;
    next_port_five_latch = port_five_latch;
    case (phase)
      PAF_IDLE, PAF_HELD: begin
        if (SFR_WR && LAST_CYCLE) begin
          // last machine cycle: commit state next, the latch takes the write one clock later
          next_pend_addr = SFR_ADDR;
          next_pend_data = SFR_WDATA;
          next_phase = PAF_COMMIT;
        end else if (SFR_WR) begin
          next_pend_addr = SFR_ADDR;
          next_pend_data = SFR_WDATA;
          next_phase = PAF_HELD;
        end else if (phase == PAF_HELD && LAST_CYCLE) begin
          next_phase = PAF_COMMIT;
        end
      end
      PAF_COMMIT: begin
        // the latch (D flip-flop) takes the value
        case (pend_addr)
          PAF_ADDR_PORT_ONE: next_port_one_latch = pend_data;
          PAF_ADDR_PORT_THREE: next_port_three_latch = pend_data;
          PAF_ADDR_PORT_FIVE: next_port_five_latch = pend_data[FIVE_WIDTH-1:0];
          default: ;
        endcase
        next_phase = SFR_WR ? PAF_HELD : PAF_IDLE;
        if (SFR_WR) begin
          next_pend_addr = SFR_ADDR;
          next_pend_data = SFR_WDATA;
          if (LAST_CYCLE) begin
            next_phase = PAF_COMMIT;
          end
        end
      end
      default: next_phase = PAF_IDLE;
    endcase
  end

  // read path: latch for read-modify-write, pins otherwise
  // read data stands one cycle only, so the core must take it at once
  always_comb begin
    next_rdata = 8'h00;
    next_hit = 1'b0;
    if (SFR_RD) begin
      case (SFR_ADDR)
        PAF_ADDR_PORT_ONE: begin
          next_hit = 1'b1;
          next_rdata = SFR_RMW ? port_one_latch : one_level;
        end
        PAF_ADDR_PORT_THREE: begin
          next_hit = 1'b1;
          next_rdata = SFR_RMW ? port_three_latch : three_level;
        end
        PAF_ADDR_PORT_FIVE: begin
          next_hit = 1'b1;
          // upper four bits unused, read as zero
          next_rdata = SFR_RMW ? paf_widen(port_five_latch) : paf_widen(five_level);
        end
        default: next_hit = 1'b0;
      endcase
    end
  end

  // peripheral inputs come from the sampled pin, so a pin held low by its
  // own latch also reads low here; software must keep the latch high
  always_comb begin
    next_t2_in[0] = one_level[PAF_BIT_T2_COUNT];
    next_t2_in[1] = one_level[PAF_BIT_T2_AUX];
    next_alt_in = three_level;
  end

  // all state registers; reset releases every pin to its pull-up
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      port_one_latch <= PAF_RESET_PORT_ONE;
      port_three_latch <= PAF_RESET_PORT_THREE;
      port_five_latch <= PAF_RESET_PORT_FIVE[FIVE_WIDTH-1:0];
      phase <= PAF_IDLE;
      pend_data <= 8'h00;
      pend_addr <= 8'h00;
      SFR_RDATA <= 8'h00;
      SFR_HIT <= 1'b0;
      one_pull <= 8'h00;
      three_pull <= 8'h00;
      five_pull <= '0;
      alt_in <= 8'hff;
      t2_in <= 2'h3;
    end else begin
      port_one_latch <= next_port_one_latch;
      port_three_latch <= next_port_three_latch;
      port_five_latch <= next_port_five_latch;
      phase <= next_phase;
      pend_data <= next_pend_data;
      pend_addr <= next_pend_addr;
      SFR_RDATA <= next_rdata;
      SFR_HIT <= next_hit;
      one_pull <= next_one_pull;
      three_pull <= next_three_pull;
      five_pull <= next_five_pull;
      alt_in <= next_alt_in;
      t2_in <= next_t2_in;
    end
  end

  // pin drive: only ever low; high comes from the pull-up outside
  // out stays low and only oe moves, which keeps the pad quasi-bidirectional
  always_comb begin
    PORT_ONE_OUT = 8'h00;
    PORT_ONE_OE = one_pull;
    PORT_THREE_OUT = 8'h00;
    PORT_THREE_OE = three_pull;
    PORT_FIVE_OUT = '0;
    PORT_FIVE_OE = five_pull;
  end

  // peripheral input fan-out
  // gate and interrupt share a pin, so both see the same sampled level
  always_comb begin
    TIMER_TWO_COUNT_IN = t2_in[0];
    TIMER_TWO_AUX_IN = t2_in[1];
    SERIAL_DATA_IN = alt_in[PAF_BIT_SERIAL_DATA];
    EXT_IRQ_ZERO_IN = alt_in[PAF_BIT_IRQ_ZERO];
    EXT_IRQ_ONE_IN = alt_in[PAF_BIT_IRQ_ONE];
    TIMER_ZERO_GATE_IN = alt_in[PAF_BIT_IRQ_ZERO];
    TIMER_ONE_GATE_IN = alt_in[PAF_BIT_IRQ_ONE];
    TIMER_ZERO_COUNT_IN = alt_in[PAF_BIT_TIMER_ZERO];
    TIMER_ONE_COUNT_IN = alt_in[PAF_BIT_TIMER_ONE];
  end
endmodule : paf_port_io
`default_nettype wire

/* File: paf_port_io_props.sv */
/*
  paf_port_io_props: assertions on the port block's top ports.
  assumes: bound into paf_port_io; one clock, RST high resets.
*/
`default_nettype none
module paf_port_io_chk
  import paf_pkg::*;
#(
  parameter int FIVE_WIDTH = PAF_PORT_FIVE_WIDTH
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_RD,
  input wire logic LAST_CYCLE,
  input wire logic [7:0] SFR_RDATA,
  input wire logic SFR_HIT,
  input wire logic MACHINE_TICK,
  input wire logic [7:0] PORT_THREE_IN,
  input wire logic [7:0] PORT_THREE_OE,
  input wire logic [FIVE_WIDTH-1:0] PORT_FIVE_OE,
  input wire logic EXT_IRQ_ZERO_IN,
  input wire logic SERIAL_SYNC_MODE,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_TX_OR_CLOCK,
  input wire logic EXT_MEM_ACTIVE,
  input wire logic EXT_WRITE_STROBE_N
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  // address hits one of the three latches
  logic mapped;
  // no alternate output pulls the third port, so drive mirrors the latch
  logic alt_idle;
  assign mapped = SFR_ADDR inside {PAF_ADDR_PORT_ONE, PAF_ADDR_PORT_THREE, PAF_ADDR_PORT_FIVE};
  assign alt_idle = !SERIAL_SYNC_MODE && SERIAL_TX_OR_CLOCK && !EXT_MEM_ACTIVE;
  a_tick_period: assert property ($rose(MACHINE_TICK) |-> ##12 MACHINE_TICK)
    else $error("machine tick spacing wrong");
  a_read_hit: assert property (SFR_RD && mapped |=> SFR_HIT)
    else $error("mapped read gave no hit");
  a_unmapped_read: assert property (SFR_RD && !mapped |=> !SFR_HIT && SFR_RDATA == 8'h00)
    else $error("unmapped read not empty");
  a_five_upper: assert property (SFR_RD && SFR_ADDR == PAF_ADDR_PORT_FIVE |=> SFR_RDATA[7:4] == 4'h0)
    else $error("fifth port upper bits not zero");
  // latch lands two edges after the committing write, drive one edge later
  a_three_commit: assert property (SFR_WR && LAST_CYCLE && SFR_ADDR == PAF_ADDR_PORT_THREE && alt_idle
    ##1 (!SFR_WR && alt_idle) [*2] |=> PORT_THREE_OE == ~$past(SFR_WDATA, 3))
    else $error("third port drive wrong after commit");
  a_five_commit: assert property (SFR_WR && LAST_CYCLE && SFR_ADDR == PAF_ADDR_PORT_FIVE
    ##1 !SFR_WR [*2] |=> PORT_FIVE_OE == ~$past(SFR_WDATA[FIVE_WIDTH-1:0], 3))
    else $error("fifth port drive wrong after commit");
  a_reset_release: assert property ($fell(RST) |-> PORT_THREE_OE == 8'h00 && PORT_FIVE_OE == '0)
    else $error("pins not released by reset");
  a_irq_follow: assert property ($stable(PORT_THREE_IN[2]) [*7] |-> EXT_IRQ_ZERO_IN == PORT_THREE_IN[2])
    else $error("interrupt input not following pin");
  a_strobe_drive: assert property (EXT_MEM_ACTIVE && !EXT_WRITE_STROBE_N |=> PORT_THREE_OE[6])
    else $error("write strobe not on pin");
  a_tx_drive: assert property (!SERIAL_TX_OR_CLOCK |=> PORT_THREE_OE[1])
    else $error("transmit low not on pin");
  a_sync_data: assert property (SERIAL_SYNC_MODE && !SERIAL_DATA_OUT |=> PORT_THREE_OE[0])
    else $error("sync data low not on pin");
  c_commit: cover property (SFR_WR && LAST_CYCLE ##3 PORT_THREE_OE != 8'h00);
  c_unmapped: cover property (SFR_RD && !mapped ##1 !SFR_HIT);
  c_irq_low: cover property ($fell(EXT_IRQ_ZERO_IN));
endmodule // paf_port_io_chk
bind paf_port_io paf_port_io_chk #(.FIVE_WIDTH(FIVE_WIDTH)) i_paf_port_io_chk (
  .REF_CLK(REF_CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA),
  .SFR_RD(SFR_RD), .LAST_CYCLE(LAST_CYCLE), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
  .MACHINE_TICK(MACHINE_TICK), .PORT_THREE_IN(PORT_THREE_IN), .PORT_THREE_OE(PORT_THREE_OE),
  .PORT_FIVE_OE(PORT_FIVE_OE), .EXT_IRQ_ZERO_IN(EXT_IRQ_ZERO_IN), .SERIAL_SYNC_MODE(SERIAL_SYNC_MODE),
  .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .SERIAL_TX_OR_CLOCK(SERIAL_TX_OR_CLOCK),
  .EXT_MEM_ACTIVE(EXT_MEM_ACTIVE), .EXT_WRITE_STROBE_N(EXT_WRITE_STROBE_N)
);
`default_nettype wire

/* File: paf_board_model.sv */
/*
  paf_board_model: board wiring around the port pins.
  assumes: OE high means the device sinks the pin; weak pull-ups.
*/
`default_nettype none
module paf_board_model
  import paf_pkg::*;
(
  input wire logic [7:0] oe_one,
  input wire logic [7:0] oe_three,
  input wire logic [PAF_PORT_FIVE_WIDTH-1:0] oe_five,
  input wire logic [7:0] sink_one,
  input wire logic [7:0] sink_three,
  input wire logic [PAF_PORT_FIVE_WIDTH-1:0] sink_five,
  output logic [7:0] pin_one,
  output logic [7:0] pin_three,
  output logic [PAF_PORT_FIVE_WIDTH-1:0] pin_five
);
  timeunit 1ns;
  timeprecision 1ns;
  // wired-and: the pull-up wins only while nobody sinks the line
  assign pin_one = ~(oe_one | sink_one);
  assign pin_three = ~(oe_three | sink_three);
  assign pin_five = ~(oe_five | sink_five);
endmodule // paf_board_model
`default_nettype wire

/* File: paf_port_io_tb.sv */
/*
  paf_port_io_tb: self-checking bench for the port block.
  assumes: pins are pull-ups with random external sinks; core and peripherals driven here.
*/
`default_nettype none
module paf_port_io_tb
  import paf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rmw = 1'b0, last = 1'b0, hit, tick;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, oe1, oe3, p1, p3, x1 = 8'h00, x3 = 8'h00, o1, o3;
  logic [3:0] x5 = 4'h0, oe5, p5, o5;
  // peripheral drivers, released by default
  logic sync = 1'b0, sdo = 1'b1, txc = 1'b1, mem = 1'b0, wstb_n = 1'b1, rstb_n = 1'b1;
  logic [4:0] pulse = 5'h1f;
  logic t2c, t2a, sdi, irq0, irq1, g0, g1, c0, c1;
  int mismatches = 0, checks_done = 0, cycles = 0;
  initial forever #50 clk = ~clk;
  paf_port_io i_paf_port_io (
    .REF_CLK(clk), .RST(rst), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_WDATA(wdata), .SFR_RD(rd),
    .SFR_RMW(rmw), .LAST_CYCLE(last), .SFR_RDATA(rdata), .SFR_HIT(hit), .MACHINE_TICK(tick),
    .PORT_ONE_IN(p1), .PORT_ONE_OUT(o1), .PORT_ONE_OE(oe1), .PORT_THREE_IN(p3), .PORT_THREE_OUT(o3),
    .PORT_THREE_OE(oe3), .PORT_FIVE_IN(p5), .PORT_FIVE_OUT(o5), .PORT_FIVE_OE(oe5),
    .TIMER_TWO_COUNT_IN(t2c), .TIMER_TWO_AUX_IN(t2a), .PULSE_OUT_A(pulse[0]), .PULSE_OUT_B(pulse[1]),
    .PULSE_OUT_C(pulse[2]), .PULSE_OUT_D(pulse[3]), .PULSE_OUT_E(pulse[4]), .SERIAL_SYNC_MODE(sync),
    .SERIAL_DATA_OUT(sdo), .SERIAL_TX_OR_CLOCK(txc), .SERIAL_DATA_IN(sdi), .EXT_IRQ_ZERO_IN(irq0),
    .EXT_IRQ_ONE_IN(irq1), .TIMER_ZERO_GATE_IN(g0), .TIMER_ONE_GATE_IN(g1), .TIMER_ZERO_COUNT_IN(c0),
    .TIMER_ONE_COUNT_IN(c1), .EXT_MEM_ACTIVE(mem), .EXT_WRITE_STROBE_N(wstb_n), .EXT_READ_STROBE_N(rstb_n)
  );
  paf_board_model i_paf_board_model (
    .oe_one(oe1), .oe_three(oe3), .oe_five(oe5), .sink_one(x1), .sink_three(x3), .sink_five(x5),
    .pin_one(p1), .pin_three(p3), .pin_five(p5)
  );
  // third port alternate outputs, 1 = released
  function automatic logic [7:0] alt_three(input logic sm, input logic so, input logic tc, input logic m,
    input logic w, input logic r);
    return {m ? r : 1'b1, m ? w : 1'b1, 4'hf, tc, sm ? so : 1'b1};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d, input logic lc);
    @(negedge clk);
    addr = a;
    wdata = d;
    last = lc;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    last = 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic m, input logic [7:0] exp,
    input logic h);
    @(negedge clk);
    addr = a;
    rmw = m;
    rd = 1'b1;
    @(negedge clk);
    check(what, rdata, exp);
    check("hit", {7'h00, hit}, {7'h00, h});
    rd = 1'b0;
    rmw = 1'b0;
  endtask
  task automatic reset_chk();
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    check("three drive", oe3, 8'h00);
    rd_chk("three latch", PAF_ADDR_PORT_THREE, 1'b1, 8'hff, 1'b1);
    rd_chk("one latch", PAF_ADDR_PORT_ONE, 1'b1, 8'hff, 1'b1);
    rd_chk("five latch", PAF_ADDR_PORT_FIVE, 1'b1, 8'h0f, 1'b1);
    $display("TB: reset test done");
  endtask
  task automatic complete_run();
    $display("TB: checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    logic [7:0] l1, l3, l5, a3, a1, q1, q3;
    int n;
    void'($urandom(98));
    reset_chk();
    // random latches, sinks and alternate outputs together
    for (int i = 0; i < 24; i++) begin
      {sync, sdo, txc, mem, wstb_n, rstb_n} = 6'($urandom);
      {pulse, x5} = 9'($urandom);
      x1 = 8'($urandom);
      x3 = 8'($urandom);
      l1 = 8'($urandom);
      l3 = 8'($urandom);
      l5 = 8'($urandom);
      sfr_write(PAF_ADDR_PORT_THREE, l3, 1'b1);
      sfr_write(PAF_ADDR_PORT_ONE, l1, 1'b1);
      sfr_write(PAF_ADDR_PORT_FIVE, l5, 1'b1);
      repeat (12) @(negedge clk);
      a3 = alt_three(sync, sdo, txc, mem, wstb_n, rstb_n);
      a1 = {pulse, 3'h7};
      q3 = l3 & a3 & ~x3;
      q1 = l1 & a1 & ~x1;
      check("three drive", oe3, ~(l3 & a3));
      check("one drive", oe1, ~(l1 & a1));
      check("five drive", {4'h0, oe5}, {4'h0, ~l5[3:0]});
      check("pin out level", o1 | o3 | {4'h0, o5}, 8'h00);
      check("three alt in", {1'b0, c1, c0, g1, irq1, g0, irq0, sdi},
        {1'b0, q3[5], q3[4], q3[3], q3[3], q3[2], q3[2], q3[0]});
      check("one alt in", {6'h00, t2a, t2c}, {6'h00, q1[1:0]});
      rd_chk("three latch", PAF_ADDR_PORT_THREE, 1'b1, l3, 1'b1);
      rd_chk("three pins", PAF_ADDR_PORT_THREE, 1'b0, q3, 1'b1);
      rd_chk("five latch", PAF_ADDR_PORT_FIVE, 1'b1, {4'h0, l5[3:0]}, 1'b1);
      rd_chk("five pins", PAF_ADDR_PORT_FIVE, 1'b0, {4'h0, l5[3:0] & ~x5}, 1'b1);
      rd_chk("one latch", PAF_ADDR_PORT_ONE, 1'b1, l1, 1'b1);
    end
    $display("TB: random port test done");
    // a write waits for the last machine cycle before it lands
    {sync, txc, mem, x3} = {1'b0, 1'b1, 1'b0, 8'h00};
    sfr_write(PAF_ADDR_PORT_THREE, 8'h5a, 1'b0);
    repeat (4) @(negedge clk);
    check("held write", oe3, ~l3);
    last = 1'b1;
    @(negedge clk);
    last = 1'b0;
    repeat (3) @(negedge clk);
    check("late commit", oe3, 8'ha5);
    sfr_write(PAF_ADDR_PORT_THREE, 8'h3c, 1'b1);
    repeat (4) @(negedge clk);
    check("commit", oe3, 8'hc3);
    sfr_write(8'ha0, 8'h00, 1'b1);
    repeat (4) @(negedge clk);
    check("unmapped write", oe3, 8'hc3);
    rd_chk("unmapped read", 8'ha0, 1'b0, 8'h00, 1'b0);
    // latch bit 2 is high (8'h3c), so the device releases the interrupt pin and only the outside sink pulls it low
    x3 = 8'h04;
    repeat (8) @(negedge clk);
    check("irq pin in", {6'h00, irq0, g0}, 8'h00);
    x3 = 8'h00;
    // free-running machine tick: one pulse per twelve clocks
    n = 0;
    repeat (24) begin
      @(negedge clk);
      n += int'(tick);
    end
    check("tick count", 8'(n), 8'(32'h18 / PAF_CLOCKS_PER_MACHINE));
    $display("TB: commit test done");
    reset_chk();
    complete_run();
  end
endmodule // paf_port_io_tb
`default_nettype wire
